// ==== cgr_clock_ctrl.sv ====
`timescale 1ns/10ps
module cgr_clock_ctrl
  import cgr_pkg::*;
#(
  parameter int         EXT_XTAL_CYCLES = CGR_EXT_XTAL_CYCLES,
  parameter logic [7:0] TRIM_5V_VALUE   = 8'hff,
  parameter logic [7:0] TRIM_3V_VALUE   = 8'hff
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Analog generator and monitor side.
  input  wire logic        internal_clock_i,
  input  wire logic        external_clock_i,
  input  wire logic        internal_lost_i,
  input  wire logic        external_lost_i,
  input  wire logic        internal_locked_i,
  input  wire logic [3:0]  filter_divide_i,
  input  wire logic [7:0]  filter_stage_i,
  // Chip modes and options.
  input  wire logic        stop_mode_i,
  input  wire logic        clocks_in_stop_option_i,
  input  wire logic        external_crystal_option_i,
  // Controls to the generators.
  output logic             monitor_irq_o,
  output logic             oscillator_output_clock_o,
  output logic             internal_gen_on_o,
  output logic             external_gen_on_o,
  output logic             monitor_on_o,
  output logic [6:0]       mult_factor_o,
  output logic [7:0]       clock_trim_o,
  output logic [3:0]       osc_divide_count_o,
  output logic [7:0]       osc_stage_count_o
);

  // Synchronised pin-side levels; stage one feeds stage two only.
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic       ext_clk_d_r;
  logic       int_clk_d_r;

  // Control register bits.
  logic irq_en_r;
  logic fail_r;
  logic mon_on_r;
  logic sel_r;
  logic int_on_r;
  logic int_stb_r;
  logic ext_on_r;
  logic ext_stb_r;
  logic fail_seen_r;

  logic [6:0]  mult_r;
  logic [7:0]  trim_r;
  logic [3:0]  div_r;
  logic [7:0]  stage_r;
  logic [12:0] ext_cnt_r;

  // Decoded bus strobes.
  // Everything below is combinational from the registers, the bus and the mode pins.
  logic        req;
  logic        wr;
  logic        rd;
  logic        wr_ctl;
  logic        wr_mult;
  logic        wr_trim;
  logic        wr_stage;
  logic        halt;
  logic        int_lost;
  logic        ext_lost;
  logic        int_clk;
  logic        ext_clk;
  logic        int_locked;
  logic        ext_edge;
  logic [12:0] ext_target;
  logic [7:0]  ctl_rd;
  logic [7:0]  rd_data;

  // Clock, loss and lock pins from the analog side pass two flops before any use.
  // The clock pins are sampled as levels, so only clocks well below half the
  // bus rate are followed faithfully; a faster clock aliases and may look lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= {internal_clock_i, external_clock_i, internal_lost_i, external_lost_i, internal_locked_i};
      sync2_r <= sync1_r;
    end
  end

  // Loss reports count only while the monitor runs. A generator that software
  // simply switched off must not raise the failure flag, and the monitor has
  // no meaningful reference for a clock that it is not watching.
  assign int_clk    = sync2_r[4];
  assign ext_clk    = sync2_r[3];
  assign int_lost   = sync2_r[2] & mon_on_r;
  assign ext_lost   = sync2_r[1] & mon_on_r;
  assign int_locked = sync2_r[0];

  // Stop without the keep-running option shuts both generators down.
  // Only the stable bits, the monitor, the irq enable and the fail flag are cleared; select, enables and
  // factors survive, so the clock returns on the same source after stop.
  assign halt = stop_mode_i & ~clocks_in_stop_option_i;

  // One-cycle access; ack is never held across two edges.
  // Only byte lane zero holds a register, so a write needs sel_i[0]. A read
  // ignores the lanes and always returns its byte in the low lane, which keeps
  // the decode small at the cost of accepting odd lane patterns on reads.
  assign req      = cyc_i & stb_i & ~ack_o;
  assign wr       = req & we_i & sel_i[0];
  assign rd       = req & ~we_i;
  assign wr_ctl   = wr & (adr_i == CGR_ADDR_CONTROL);
  assign wr_mult  = wr & (adr_i == CGR_ADDR_MULTIPLIER) & ~mon_on_r;
  assign wr_trim  = wr & (adr_i == CGR_ADDR_TRIM) & ~mon_on_r;
  assign wr_stage = wr & (adr_i == CGR_ADDR_STAGE) & ~int_on_r;

  // The request is masked while ack is high, so a master that keeps stb up
  // for one extra edge still gets exactly one acknowledge per transfer.
  // The price is a dead cycle between back-to-back requests.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Monitor interrupt enable; may only be set, and only stays set, while the monitor is on.
  always_ff @(posedge clk_i) begin
    if (rst_i || !mon_on_r || halt) begin
      irq_en_r <= 1'b0;
    end else if (wr_ctl) begin
      irq_en_r <= dat_i[CGR_BIT_IRQ_EN];
    end
  end

  // Fail flag: a detection in the clearing cycle wins over the clear.
  // The arming read is remembered in fail_seen_r, so a blind write of zero
  // cannot discard a failure that software has never looked at. A fresh
  // detection leaves the arming in place, as the flag is still set.
  always_ff @(posedge clk_i) begin
    if (rst_i || !mon_on_r || halt) begin
      fail_r      <= 1'b0;
      fail_seen_r <= 1'b0;
    end else if (int_lost || ext_lost) begin
      fail_r <= 1'b1;
    end else begin
      if (rd && adr_i == CGR_ADDR_CONTROL && fail_r) begin
        fail_seen_r <= 1'b1;
      end
      if (wr_ctl && fail_seen_r && !dat_i[CGR_BIT_FAIL]) begin
        fail_r      <= 1'b0;
        fail_seen_r <= 1'b0;
      end
    end
  end

  // Monitor on: the flag holds it up so the flag cannot be lost by accident.
  // A write that turns the monitor on must keep both generators on as well;
  // otherwise the monitor would show on for one cycle and be forced off again.
  always_ff @(posedge clk_i) begin
    if (rst_i || !int_on_r || !ext_on_r || halt) begin
      mon_on_r <= 1'b0;
    end else if (fail_r) begin
      mon_on_r <= 1'b1;
    end else if (wr_ctl) begin
      if (dat_i[CGR_BIT_MON_ON]) begin
        mon_on_r <= mon_on_r | (int_on_r & ext_on_r & int_stb_r & ext_stb_r
                                & dat_i[CGR_BIT_INT_ON] & dat_i[CGR_BIT_EXT_ON]);
      end else begin
        mon_on_r <= 1'b0;
      end
    end
  end

  // Clock select with forced moves on loss or generator off.
  // External loss wins over internal loss: with both gone the output falls
  // back to the internal path, and the failure flag tells software why.
  // A write may not move the select onto a generator that it turns off.
  always_ff @(posedge clk_i) begin
    if (rst_i || ext_lost || !ext_on_r) begin
      sel_r <= 1'b0;
    end else if (int_lost || !int_on_r) begin
      sel_r <= 1'b1;
    end else if (wr_ctl) begin
      if (dat_i[CGR_BIT_SEL]) begin
        sel_r <= sel_r | (ext_on_r & ext_stb_r & dat_i[CGR_BIT_EXT_ON]);
      end else begin
        sel_r <= sel_r & ~(int_on_r & int_stb_r & dat_i[CGR_BIT_INT_ON]);
      end
    end
  end

  // Internal generator on; turning it off is only safe when unused.
  // Both conditions are the register values before the write edge, so the
  // external path has carried the output for at least one cycle before the
  // internal generator is allowed to stop.
  always_ff @(posedge clk_i) begin
    if (rst_i || mon_on_r || !sel_r) begin
      int_on_r <= 1'b1;
    end else if (wr_ctl) begin
      int_on_r <= dat_i[CGR_BIT_INT_ON];
    end
  end

  // External generator on; held while selected or monitored.
  // Unlike the internal generator it comes up off, since no clock may be fitted.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_on_r <= 1'b0;
    end else if (mon_on_r || sel_r) begin
      ext_on_r <= 1'b1;
    end else if (wr_ctl) begin
      ext_on_r <= dat_i[CGR_BIT_EXT_ON];
    end
  end

  // Internal stable follows the loop lock, dropped on any retune.
  // Lock passes the two synchroniser flops first, so the bit lags the loop by
  // three bus cycles; a retune clears it for one cycle only, after which it reloads the synchronised lock, stale or not.
  always_ff @(posedge clk_i) begin
    if (rst_i || int_lost || !int_on_r || wr_mult || wr_trim || halt) begin
      int_stb_r <= 1'b0;
    end else begin
      int_stb_r <= int_locked;
    end
  end

  // External start-up counter, counted in synchronised rising edges.
  // Each external edge counts once only while the external clock runs below
  // half the bus rate. Thirteen bits cover the long crystal count, and
  // without the crystal option the short count applies instead.
  assign ext_edge   = ext_clk & ~ext_clk_d_r;
  assign ext_target = external_crystal_option_i ? 13'(EXT_XTAL_CYCLES) : 13'(CGR_EXT_CLK_CYCLES);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_clk_d_r <= 1'b0;
    end else begin
      ext_clk_d_r <= ext_clk;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || ext_lost || !ext_on_r || halt) begin
      ext_cnt_r <= 13'h0000;
      ext_stb_r <= 1'b0;
    end else if (ext_edge && !ext_stb_r) begin
      ext_cnt_r <= ext_cnt_r + 13'h0001;
      if (ext_cnt_r + 13'h0001 >= ext_target) begin
        ext_stb_r <= 1'b1;
      end
    end
  end

  // Multiplier and trim, both locked while the monitor runs.
  // A zero multiplier is stored as written so software reads back what it
  // wrote; only the factor sent to the generator is mapped to one. Either
  // write also drops the internal stable bit, handled with that bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mult_r <= CGR_MULT_RESET;
      trim_r <= CGR_TRIM_RESET;
    end else begin
      if (wr_mult) begin
        mult_r <= dat_i[6:0];
      end
      if (wr_trim) begin
        trim_r <= dat_i[7:0];
      end
    end
  end

  // Loop-filter readbacks; deliberately no reset, as reset turns the internal generator on and they follow the filter.
  // While the internal generator runs the filter owns both fields, which is
  // why a stage write is only taken with the generator off. The divider has
  // no write path at all here.
  always_ff @(posedge clk_i) begin
    if (int_on_r) begin
      div_r   <= (filter_divide_i > CGR_DIV_MAX) ? CGR_DIV_MAX : filter_divide_i;
      stage_r <= filter_stage_i;
    end else if (wr_stage) begin
      stage_r <= dat_i[7:0];
    end
  end

  // Read mux; unmapped addresses read as zero.
  // The trim stores are fixed at build time by parameter, and the options
  // readback lets software see how the chip was strapped. Reads have no side
  // effect except arming the clear of the failure flag.
  assign ctl_rd = {irq_en_r, fail_r, mon_on_r, sel_r, int_on_r, int_stb_r, ext_on_r, ext_stb_r};

  always_comb begin
    rd_data = 8'h00;
    unique case (adr_i)
      CGR_ADDR_CONTROL:    rd_data = ctl_rd;
      CGR_ADDR_MULTIPLIER: rd_data = {1'b0, mult_r};
      CGR_ADDR_TRIM:       rd_data = trim_r;
      CGR_ADDR_DIVIDER:    rd_data = {4'h0, div_r};
      CGR_ADDR_STAGE:      rd_data = stage_r;
      CGR_ADDR_TRIM_5V:    rd_data = TRIM_5V_VALUE;
      CGR_ADDR_TRIM_3V:    rd_data = TRIM_3V_VALUE;
      CGR_ADDR_STRAPS:     rd_data = {6'h00, external_crystal_option_i, clocks_in_stop_option_i};
      default:             rd_data = 8'h00;
    endcase
  end

  // Read data stays until the next read, so a slow master may still take it
  // after ack; the upper bytes are always zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      dat_o <= {24'h00_0000, rd_data};
    end
  end

  // Registered outputs to the generators.
  // Every output lags its register bit by one bus cycle. The monitor output
  // also drops in stop, together with the generator enables, so it never shows
  // the monitor on while both generators are held off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      monitor_irq_o             <= 1'b0;
      oscillator_output_clock_o <= 1'b0;
      internal_gen_on_o         <= 1'b1;
      external_gen_on_o         <= 1'b0;
      monitor_on_o              <= 1'b0;
      mult_factor_o             <= CGR_MULT_RESET;
      clock_trim_o              <= CGR_TRIM_RESET;
      osc_divide_count_o        <= 4'h0;
      osc_stage_count_o         <= 8'h00;
    end else begin
      monitor_irq_o             <= irq_en_r & fail_r;
      oscillator_output_clock_o <= halt ? 1'b0 : (sel_r ? ext_clk : int_clk);
      internal_gen_on_o         <= int_on_r & ~halt;
      external_gen_on_o         <= ext_on_r & ~halt;
      monitor_on_o              <= mon_on_r & ~halt;
      mult_factor_o             <= (mult_r == CGR_MULT_ZERO) ? CGR_MULT_ONE : mult_r;
      clock_trim_o              <= trim_r;
      osc_divide_count_o        <= div_r;
      osc_stage_count_o         <= stage_r;
    end
  end

endmodule

// ==== cgr_pkg.sv ====
package cgr_pkg;

  // Register byte addresses on the bus (one aligned word each, except the two trim stores, which share one word).
  localparam logic [15:0] CGR_ADDR_CONTROL    = 16'h0000;
  localparam logic [15:0] CGR_ADDR_MULTIPLIER = 16'h0004;
  localparam logic [15:0] CGR_ADDR_TRIM       = 16'h0008;
  localparam logic [15:0] CGR_ADDR_DIVIDER    = 16'h000c;
  localparam logic [15:0] CGR_ADDR_STAGE      = 16'h0010;
  localparam logic [15:0] CGR_ADDR_TRIM_5V    = 16'hff80;
  localparam logic [15:0] CGR_ADDR_TRIM_3V    = 16'hff81;
  localparam logic [15:0] CGR_ADDR_STRAPS     = 16'h0014;

  // Field positions inside clock_gen_control.
  localparam int CGR_BIT_IRQ_EN  = 7;
  localparam int CGR_BIT_FAIL    = 6;
  localparam int CGR_BIT_MON_ON  = 5;
  localparam int CGR_BIT_SEL     = 4;
  localparam int CGR_BIT_INT_ON  = 3;
  localparam int CGR_BIT_INT_STB = 2;
  localparam int CGR_BIT_EXT_ON  = 1;
  localparam int CGR_BIT_EXT_STB = 0;

  // Values after reset, and the multiplier and divider limits.
  localparam logic [6:0] CGR_MULT_RESET = 7'h15;
  localparam logic [7:0] CGR_TRIM_RESET = 8'h80;
  localparam logic [6:0] CGR_MULT_ZERO  = 7'h00;
  localparam logic [6:0] CGR_MULT_ONE   = 7'h01;
  localparam logic [3:0] CGR_DIV_MAX    = 4'h9;

  // External stabilisation counts in external clock cycles.
  localparam int CGR_EXT_XTAL_CYCLES = 4096;
  localparam int CGR_EXT_CLK_CYCLES  = 16;

endpackage

// ==== cgr_ctrl_properties.sv ====
`timescale 1ns/10ps
module cgr_ctrl_properties
  import cgr_pkg::*;
(
  // Clock and reset.
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Bus and modes.
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       stop_mode_i,
  input wire logic       clocks_in_stop_option_i,
  // Block outputs.
  input wire logic       monitor_irq_o,
  input wire logic       monitor_on_o,
  input wire logic       internal_gen_on_o,
  input wire logic       external_gen_on_o,
  input wire logic       oscillator_output_clock_o,
  input wire logic [6:0] mult_factor_o,
  input wire logic [7:0] clock_trim_o,
  input wire logic [3:0] osc_divide_count_o
);
  // All checks share the bus clock and are quiet during reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A fresh request, and stop mode without the clocks option.
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_halt; stop_mode_i && !clocks_in_stop_option_i; endsequence

  // Each property ties an output to its cause with the exact delay, or to a fixed bound.
  property p_ack; s_take |=> ack_o ##1 !ack_o; endproperty
  property p_irq; monitor_irq_o |-> $past(monitor_on_o); endproperty
  property p_gens; monitor_on_o |-> internal_gen_on_o && external_gen_on_o; endproperty
  property p_rst; $fell(rst_i) |-> internal_gen_on_o && !external_gen_on_o && !monitor_on_o
    && mult_factor_o == CGR_MULT_RESET && clock_trim_o == CGR_TRIM_RESET; endproperty
  property p_lock; monitor_on_o |=> $stable(mult_factor_o) && $stable(clock_trim_o); endproperty
  property p_mult; mult_factor_o != CGR_MULT_ZERO; endproperty
  property p_div; internal_gen_on_o |=> osc_divide_count_o <= CGR_DIV_MAX; endproperty
  property p_stop; s_halt |=> !monitor_on_o && !oscillator_output_clock_o; endproperty

  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_irq: assert property (p_irq) else $error("irq without monitor on");
  a_gens: assert property (p_gens) else $error("monitor on with a generator off");
  a_rst: assert property (p_rst) else $error("wrong values after reset");
  a_lock: assert property (p_lock) else $error("factor changed while monitoring");
  a_mult: assert property (p_mult) else $error("zero multiplier shown");
  a_div: assert property (p_div) else $error("divider above nine");
  a_stop: assert property (p_stop) else $error("clocks active in stop");
endmodule

bind cgr_clock_ctrl cgr_ctrl_properties i_cgr_ctrl_properties (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .stop_mode_i, .clocks_in_stop_option_i,
  .monitor_irq_o, .monitor_on_o, .internal_gen_on_o, .external_gen_on_o,
  .oscillator_output_clock_o, .mult_factor_o, .clock_trim_o, .osc_divide_count_o
);

// ==== cgr_clock_ctrl_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module cgr_clock_ctrl_tb_top
  import cgr_pkg::*;
  ;
  // Stimulus, all given a value at time zero.
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [15:0] adr_i = 16'h0000;
  logic [31:0] dat_i = 32'h00000000;
  logic        int_lost = 1'b0, locked = 1'b0, stop = 1'b0;
  logic        keep = 1'b0, xtal = 1'b1;
  logic [2:0]  div_r = 3'h0;
  // Observed outputs.
  logic [31:0] dat_o;
  logic        ack_o, irq, oclk, int_on, ext_on, mon_on;
  logic [6:0]  mult;
  logic [7:0]  trim, stage;
  logic [3:0]  divc;
  logic [7:0]  q;
  int          miscompares = 0, checks = 0;

  // Bus clock; the slow divider gives the two sampled clocks.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) div_r <= div_r + 3'h1;

  // A short stabilisation count keeps the run brief.
  cgr_clock_ctrl #(.EXT_XTAL_CYCLES(8), .TRIM_5V_VALUE(8'h5a), .TRIM_3V_VALUE(8'ha5)) i_cgr_clock_ctrl (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1), .dat_i, .dat_o, .ack_o,
    .internal_clock_i(div_r[2]), .external_clock_i(div_r[1]), .internal_lost_i(int_lost),
    .external_lost_i(1'b0), .internal_locked_i(locked), .filter_divide_i(4'hc),
    .filter_stage_i(8'h77), .stop_mode_i(stop), .clocks_in_stop_option_i(keep),
    .external_crystal_option_i(xtal), .monitor_irq_o(irq), .oscillator_output_clock_o(oclk),
    .internal_gen_on_o(int_on), .external_gen_on_o(ext_on), .monitor_on_o(mon_on),
    .mult_factor_o(mult), .clock_trim_o(trim), .osc_divide_count_o(divc), .osc_stage_count_o(stage)
  );

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One classic cycle; the request holds until ack is seen at an edge, and a slave with no ack within 20 edges fails the test.
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[7:0];
    if (ack_o !== 1'b1) begin
      miscompares++;
      final_report();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Register write, and masked register read with compare.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    `CHK(q & m, e)
  endtask

  // Main sequence: reset values, interlocks, failure handling, stop.
  initial begin
    int n;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(CGR_ADDR_CONTROL, 8'hff, 8'h08);
    rc(CGR_ADDR_MULTIPLIER, 8'hff, 8'h15);
    rc(CGR_ADDR_TRIM, 8'hff, 8'h80);
    rc(CGR_ADDR_TRIM_5V, 8'hff, 8'h5a);
    rc(CGR_ADDR_TRIM_3V, 8'hff, 8'ha5);
    rc(16'h0020, 8'hff, 8'h00);
    wr(CGR_ADDR_MULTIPLIER, 8'h00);
    `CHK(mult, CGR_MULT_ONE)
    wr(CGR_ADDR_MULTIPLIER, 8'h15);
    wr(CGR_ADDR_TRIM, 8'h7f);
    rc(CGR_ADDR_TRIM, 8'hff, 8'h7f);
    `CHK(trim, 8'h7f)
    wr(CGR_ADDR_CONTROL, 8'h80);
    rc(CGR_ADDR_CONTROL, 8'hff, 8'h08);
    locked <= 1'b1;
    wr(CGR_ADDR_CONTROL, 8'h0a);
    rc(CGR_ADDR_CONTROL, 8'hff, 8'h0e);
    wr(CGR_ADDR_CONTROL, 8'h2a);
    rc(CGR_ADDR_CONTROL, 8'h21, 8'h00);
    for (n = 0; n < 30 && q[0] !== 1'b1; n++) begin
      bus(CGR_ADDR_CONTROL, 1'b0, 8'h00);
    end
    `CHK(q, 8'h0f)
    wr(CGR_ADDR_CONTROL, 8'h2a);
    `CHK(mon_on, 1'b1)
    wr(CGR_ADDR_CONTROL, 8'haa);
    rc(CGR_ADDR_CONTROL, 8'hff, 8'haf);
    wr(CGR_ADDR_MULTIPLIER, 8'h33);
    rc(CGR_ADDR_MULTIPLIER, 8'hff, 8'h15);
    wr(CGR_ADDR_TRIM, 8'h11);
    rc(CGR_ADDR_TRIM, 8'hff, 8'h7f);
    `CHK(trim, 8'h7f)
    int_lost <= 1'b1;
    repeat (4) @(posedge clk_i);
    int_lost <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(CGR_ADDR_CONTROL, 8'h8a);
    rc(CGR_ADDR_CONTROL, 8'he0, 8'he0);
    wr(CGR_ADDR_CONTROL, 8'h8a);
    rc(CGR_ADDR_CONTROL, 8'h60, 8'h20);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    wr(CGR_ADDR_CONTROL, 8'h32);
    `CHK(int_on, 1'b1)
    wr(CGR_ADDR_CONTROL, 8'h12);
    wr(CGR_ADDR_CONTROL, 8'h12);
    `CHK(int_on, 1'b0)
    `CHK(ext_on, 1'b1)
    wr(CGR_ADDR_CONTROL, 8'h00);
    rc(CGR_ADDR_CONTROL, 8'h1a, 8'h12);
    wr(CGR_ADDR_STAGE, 8'h3c);
    rc(CGR_ADDR_STAGE, 8'hff, 8'h3c);
    wr(CGR_ADDR_CONTROL, 8'h1a);
    wr(CGR_ADDR_STAGE, 8'h55);
    rc(CGR_ADDR_STAGE, 8'hff, 8'h77);
    rc(CGR_ADDR_DIVIDER, 8'h0f, 8'h09);
    `CHK(divc, 4'h9)
    `CHK(stage, 8'h77)
    stop <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(oclk, 1'b0)
    `CHK(int_on, 1'b0)
    `CHK(ext_on, 1'b0)
    rc(CGR_ADDR_CONTROL, 8'h25, 8'h00);
    // Keep clocks in stop and use the short external count.
    xtal <= 1'b0;
    keep <= 1'b1;
    repeat (40) @(posedge clk_i);
    `CHK(int_on, 1'b1)
    rc(CGR_ADDR_STRAPS, 8'hff, 8'h01);
    rc(CGR_ADDR_CONTROL, 8'h01, 8'h00);
    repeat (50) @(posedge clk_i);
    rc(CGR_ADDR_CONTROL, 8'h01, 8'h01);
    final_report();
  end
endmodule
